// File: design/pps_defines.svh
/*
  Constants of the pulse-per-second disciplining block: timing, register
  offsets, field positions and reset values.
  Assumes a 25 MHz system clock and 32-bit word-aligned registers.
*/
// Operation
// - Lock-indicator mode drives pin high while unlocked, low while locked.
// - Inverted lock-indicator mode drives pin low while unlocked, high while locked.
// - Any single status word bit may be chosen as the pin source.
// - Pin mode is chosen by its own field, apart from bit selection.
// - Pulse mode, locked and heated: about 10 us high each second.
// - Inverted pulse mode, locked and heated: about 10 us low each second.
// - Not locked and heated: pulse mode steady high, inverted steady low.
// - Pin mode after reset is the plain pulse mode.
// - Averaging state 0..6 selects 1,16,128,512,2048,8192,32768 seconds.
// - Phase values are averaged, one correction per averaging interval.
// - Acquisition starts when heated, seeks two pulses within 50 ns timing.
// - After acquisition the internal second realigns to the next pulse.
// - Sixteen gates within 500 ns enable regulation, else acquisition restarts.
// - External lock flag sets after one hour within 50 ns.
// - A phase beyond 50 ns clears the hour counter.
// - Proportional term: gain times phase error over 2.16 ns, opposite sign.
// - Integral term ramps by its gain per interval while error nonzero.
// - One tuning word step equals 1.57e-14 fractional frequency.
// - Tracking enable bit: off runs free, on runs the disciplining sequence.
// - Mode commands arrive from the host command link; here they are Wishbone writes to the control register.
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH

`define CLK_PERIOD_NS 40
`define CLK_PERIOD_PS 40000
`define PPS_PERIOD_NS 1000000000
`define OUT_PULSE_NS 10000
`define ACQ_TOL_NS 50
`define GATE_TOL_NS 500
`define LOCK_TOL_NS 50
`define LOCK_HOLD_S 3600
`define GATE_COUNT 16
`define TUNE_PHASE_PS 2160
// Tuning word step in units of 1e-16 fractional frequency
`define TUNE_LSB_E16 157

`define REG_CTRL 8'h00
`define REG_GAIN 8'h04
`define REG_STATUS 8'h08
`define REG_TUNE 8'h0C
`define REG_PHASE 8'h10
`define REG_STATE 8'h14

`define CTRL_RST 32'h0000_0103
`define GAIN_RST 32'h0002_00C8

`define ST_RB_LOCK 16
`define ST_LAMP_HOT 20
`define ST_CELL_HOT 21
`define ST_EXT_LOCK 23
`define ST_MPO_EN 24
`define ST_TRACK 25

`define MODE_PULSE 3'h1
`define MODE_PULSE_INV 3'h2
`define MODE_LOCK 3'h5
`define MODE_LOCK_INV 3'h6
`define AVG_BAD 3'h7

`endif

// File: design/pps_pkg.sv
/*
  Types of the pulse-per-second disciplining block.
  Field layout of the control word matches CTRL_RST in pps_defines.svh.
*/
package pps_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_SEARCH, ST_ALIGN, ST_GATE, ST_RUN} disc_state_e;

  typedef struct packed {
    logic [19:0] rsvd;
    logic [2:0] avg;
    logic [4:0] sel;
    logic [2:0] mode;
    logic track;
  } ctrl_s;

  typedef struct packed {
    logic ext_lock;
    logic regulating;
    logic [2:0] state;
  } disc_stat_s;
endpackage

// File: design/pps_discipline.sv
/*
  Pulse-per-second disciplining: acquisition, gate check, averaged PI
  correction of a tuning word, one-hour lock flag and the multipurpose pin.
  Assumes status_i comes from same-clock logic; pps_in_i is an async pin.
*/
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ns
`include "pps_defines.svh"
module pps_discipline #(
  parameter int SEC_CYC = `PPS_PERIOD_NS / `CLK_PERIOD_NS,
  parameter int LOCK_SEC = `LOCK_HOLD_S
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Device status and reference pulse
  input wire logic [31:0] status_i,
  input wire logic pps_in_i,
  // Results
  output logic mpo_o,
  output logic [31:0] tune_o,
  output logic tune_stb_o,
  output pps_pkg::disc_stat_s stat_o
);
  import pps_pkg::*;

  localparam int PULSE_CYC = `OUT_PULSE_NS / `CLK_PERIOD_NS;
  localparam int ACQ_C = `ACQ_TOL_NS / `CLK_PERIOD_NS;
  localparam int GATE_C = `GATE_TOL_NS / `CLK_PERIOD_NS;
  localparam int LOCK_C = `LOCK_TOL_NS / `CLK_PERIOD_NS;
  localparam logic [31:0] ACQ_TOL = 32'((ACQ_C < 1) ? 1 : ACQ_C);
  localparam logic [31:0] GATE_TOL = 32'((GATE_C < 1) ? 1 : GATE_C);
  localparam logic [31:0] LOCK_TOL = 32'((LOCK_C < 1) ? 1 : LOCK_C);
  localparam logic [31:0] SEC = 32'(SEC_CYC);
  localparam logic [31:0] HALF = 32'(SEC_CYC / 2);
  localparam logic [31:0] PULSE = 32'(PULSE_CYC);
  localparam logic [15:0] LOCK_LAST = 16'(LOCK_SEC - 1);
  localparam logic [4:0] GATE_LAST = 5'(`GATE_COUNT - 1);

  // Averaging interval as a power of two of seconds
  function automatic logic [3:0] avg_shift(input logic [2:0] a);
    case (a)
      3'h1: avg_shift = 4'h4;
      3'h2: avg_shift = 4'h7;
      3'h3: avg_shift = 4'h9;
      3'h4: avg_shift = 4'hB;
      3'h5: avg_shift = 4'hD;
      3'h6: avg_shift = 4'hF;
      default: avg_shift = 4'h0;
    endcase
  endfunction

  ctrl_s ctrl_ff;
  logic [31:0] gain_ff;
  disc_state_e state_ff;
  logic s1_ff, s2_ff, s3_ff;
  logic [31:0] sec_cnt_ff, ival_ff, phase_ff;
  logic have_first_ff;
  logic [4:0] gate_cnt_ff;
  logic [15:0] hour_cnt_ff, avg_cnt_ff;
  logic ext_lock_ff;
  logic signed [47:0] acc_ff;
  logic signed [31:0] avg_err_ff, integ_ff;
  logic pi_go_ff;
  logic ack_ff;

  logic pps_edge, heated, ready, pulse_on, sel_bit, acq_ok, avg_last;
  logic signed [31:0] err;
  logic [31:0] abs_err, status_w, wmask;
  logic [15:0] avg_len;
  logic signed [47:0] sum;
  logic signed [31:0] nxt_integ, nxt_tune;
  logic signed [63:0] prop;
  ctrl_s nxt_ctrl;

  // Reference pin synchroniser and rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pps_in_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end
  assign pps_edge = s2_ff & ~s3_ff;

  always_comb begin
    status_w = status_i;
    status_w[`ST_EXT_LOCK] = ext_lock_ff;
    status_w[`ST_MPO_EN] = 1'b1;
    status_w[`ST_TRACK] = ctrl_ff.track;
  end
  assign heated = status_i[`ST_LAMP_HOT] & status_i[`ST_CELL_HOT];
  assign ready = status_i[`ST_RB_LOCK] & heated;

  // Internal second on the system clock, free running except for realignment in ST_ALIGN
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sec_cnt_ff <= 32'h0;
    end else if (state_ff == ST_ALIGN && pps_edge) begin
      sec_cnt_ff <= 32'h0;
    end else if (sec_cnt_ff == SEC - 32'h1) begin
      sec_cnt_ff <= 32'h0;
    end else begin
      sec_cnt_ff <= sec_cnt_ff + 32'h1;
    end
  end

  // Phase in cycles; an edge in step with the second meets the count at SEC - 1
  always_comb begin
    if (sec_cnt_ff < HALF) begin
      err = signed'(sec_cnt_ff + 32'h1);
    end else begin
      err = signed'(sec_cnt_ff + 32'h1 - SEC);
    end
    abs_err = (err < 0) ? 32'(-err) : 32'(err);
  end

  // Spacing of input edges during acquisition
  always_ff @(posedge clk_i) begin
    if (rst_i || pps_edge) begin
      ival_ff <= 32'h0;
    end else if (ival_ff != 32'hFFFF_FFFF) begin
      ival_ff <= ival_ff + 32'h1;
    end
  end
  assign acq_ok = (ival_ff + 32'h1 >= SEC - ACQ_TOL) && (ival_ff + 32'h1 <= SEC + ACQ_TOL);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_ff <= 32'h0;
    end else if (pps_edge && state_ff != ST_IDLE) begin
      phase_ff <= 32'(err);
    end
  end

  // Tracking sequence
  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_ff.track) begin
      state_ff <= ST_IDLE;
      have_first_ff <= 1'b0;
      gate_cnt_ff <= 5'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          have_first_ff <= 1'b0;
          if (heated) begin
            state_ff <= ST_SEARCH;
          end
        end
        ST_SEARCH: begin
          if (!heated) begin
            state_ff <= ST_IDLE;
          end else if (pps_edge) begin
            have_first_ff <= 1'b1;
            if (have_first_ff && acq_ok) begin
              state_ff <= ST_ALIGN;
            end
          end
        end
        ST_ALIGN: begin
          gate_cnt_ff <= 5'h0;
          if (pps_edge) begin
            state_ff <= ST_GATE;
          end
        end
        ST_GATE: begin
          if (pps_edge) begin
            if (abs_err > GATE_TOL) begin
              state_ff <= ST_SEARCH;
              have_first_ff <= 1'b0;
            end else if (gate_cnt_ff == GATE_LAST) begin
              state_ff <= ST_RUN;
            end else begin
              gate_cnt_ff <= gate_cnt_ff + 5'h1;
            end
          end
        end
        ST_RUN: begin
          state_ff <= ST_RUN;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // One-hour qualification of the external lock
  always_ff @(posedge clk_i) begin
    if (rst_i || state_ff != ST_RUN) begin
      hour_cnt_ff <= 16'h0;
      ext_lock_ff <= 1'b0;
    end else if (pps_edge) begin
      if (abs_err > LOCK_TOL) begin
        hour_cnt_ff <= 16'h0;
        ext_lock_ff <= 1'b0;
      end else if (hour_cnt_ff == LOCK_LAST) begin
        ext_lock_ff <= 1'b1;
      end else begin
        hour_cnt_ff <= hour_cnt_ff + 16'h1;
      end
    end
  end

  // Averaging prefilter
  assign avg_len = 16'h1 << avg_shift(ctrl_ff.avg);
  assign avg_last = (avg_cnt_ff == avg_len - 16'h1);
  assign sum = acc_ff + 48'(err);

  always_ff @(posedge clk_i) begin
    if (rst_i || state_ff != ST_RUN) begin
      acc_ff <= 48'sh0;
      avg_cnt_ff <= 16'h0;
      avg_err_ff <= 32'sh0;
      pi_go_ff <= 1'b0;
    end else begin
      pi_go_ff <= 1'b0;
      if (pps_edge) begin
        if (avg_last) begin
          avg_err_ff <= 32'(sum >>> avg_shift(ctrl_ff.avg));
          acc_ff <= 48'sh0;
          avg_cnt_ff <= 16'h0;
          pi_go_ff <= 1'b1;
        end else begin
          acc_ff <= sum;
          avg_cnt_ff <= avg_cnt_ff + 16'h1;
        end
      end
    end
  end

  // Proportional-integral correction; tuning word step is TUNE_LSB_E16
  always_comb begin
    if (avg_err_ff > 0) begin
      nxt_integ = integ_ff - signed'({16'h0, gain_ff[31:16]});
    end else if (avg_err_ff < 0) begin
      nxt_integ = integ_ff + signed'({16'h0, gain_ff[31:16]});
    end else begin
      nxt_integ = integ_ff;
    end
    prop = signed'({48'h0, gain_ff[15:0]}) * 64'(avg_err_ff) * 64'sd`CLK_PERIOD_PS
      / 64'sd`TUNE_PHASE_PS;
    nxt_tune = nxt_integ - 32'(prop);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      integ_ff <= 32'sh0;
      tune_o <= 32'h0;
      tune_stb_o <= 1'b0;
    end else begin
      tune_stb_o <= pi_go_ff;
      if (pi_go_ff) begin
        integ_ff <= nxt_integ;
        tune_o <= 32'(nxt_tune);
      end
    end
  end

  // Multipurpose pin
  assign pulse_on = sec_cnt_ff < PULSE;
  assign sel_bit = status_w[ctrl_ff.sel];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mpo_o <= 1'b1;
    end else begin
      case (ctrl_ff.mode)
        `MODE_PULSE: mpo_o <= ready ? pulse_on : 1'b1;
        `MODE_PULSE_INV: mpo_o <= ready ? ~pulse_on : 1'b0;
        `MODE_LOCK: mpo_o <= ~sel_bit;
        `MODE_LOCK_INV: mpo_o <= sel_bit;
        default: mpo_o <= 1'b0;
      endcase
    end
  end

  assign stat_o = '{ext_lock: ext_lock_ff, regulating: state_ff == ST_RUN, state: state_ff};

  // Register access: one-cycle registered answer
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  always_comb begin
    nxt_ctrl = ctrl_s'((ctrl_ff & ~wmask) | (wb_dat_i & wmask));
    nxt_ctrl.rsvd = 20'h0;
    if (nxt_ctrl.avg == `AVG_BAD) begin
      nxt_ctrl.avg = ctrl_ff.avg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
    end
  end
  assign wb_ack_o = ack_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= ctrl_s'(`CTRL_RST);
      gain_ff <= `GAIN_RST;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff) begin
      if (wb_adr_i == `REG_CTRL) begin
        ctrl_ff <= nxt_ctrl;
      end
      if (wb_adr_i == `REG_GAIN) begin
        gain_ff <= (gain_ff & ~wmask) | (wb_dat_i & wmask);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff) begin
      case (wb_adr_i)
        `REG_CTRL: wb_dat_o <= 32'(ctrl_ff);
        `REG_GAIN: wb_dat_o <= gain_ff;
        `REG_STATUS: wb_dat_o <= status_w;
        `REG_TUNE: wb_dat_o <= tune_o;
        `REG_PHASE: wb_dat_o <= phase_ff;
        `REG_STATE: wb_dat_o <= {hour_cnt_ff, 8'h0, gate_cnt_ff[3:0], 1'b0, state_ff};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_lock_mode_pin: assert property ((ctrl_ff.mode == `MODE_LOCK) |=>
    (mpo_o == !$past(sel_bit))) else $error("lock mode pin wrong");
  a_lock_inv_pin: assert property ((ctrl_ff.mode == `MODE_LOCK_INV) |=>
    (mpo_o == $past(sel_bit))) else $error("inverted lock mode pin wrong");
  a_pulse_high_out: assert property ((ctrl_ff.mode == `MODE_PULSE && ready &&
    sec_cnt_ff == 32'h0) |=> mpo_o ##1 mpo_o) else $error("pulse not high");
  a_pulse_inv_low: assert property ((ctrl_ff.mode == `MODE_PULSE_INV && ready &&
    sec_cnt_ff == PULSE) |=> mpo_o) else $error("inverted pulse not ended");
  a_unready_steady: assert property ((!ready && ctrl_ff.mode == `MODE_PULSE) |=>
    mpo_o) else $error("pin not steady high before ready");
  a_start_heated: assert property ((state_ff == ST_IDLE) ##1 (state_ff == ST_SEARCH) |->
    $past(heated)) else $error("acquisition without heat");
  a_gate_pass_run: assert property ((state_ff == ST_GATE && pps_edge &&
    gate_cnt_ff == GATE_LAST && abs_err <= GATE_TOL && ctrl_ff.track) |=> (state_ff == ST_RUN))
    else $error("gates passed without regulation");
  a_hour_clear: assert property ((state_ff == ST_RUN && pps_edge &&
    abs_err > LOCK_TOL) |=> (hour_cnt_ff == 16'h0 && !ext_lock_ff))
    else $error("hour counter not cleared");
  a_lock_after_hour: assert property ($rose(ext_lock_ff) |->
    $past(hour_cnt_ff) == LOCK_LAST) else $error("lock before one hour");
  a_track_off_idle: assert property ((!ctrl_ff.track) |=> (state_ff == ST_IDLE))
    else $error("tracking off but sequence active");
  a_avg_bad_kept: assert property ((wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff &&
    wb_adr_i == `REG_CTRL && wb_sel_i[1] && wb_dat_i[11:9] == `AVG_BAD) |=>
    (ctrl_ff.avg == $past(ctrl_ff.avg))) else $error("averaging state 7 accepted");
endmodule

// File: test/pps_source.sv
/*
  Model of the external reference pulse source driving the pulse input.
  Assumes it runs on the bench clock; PERIOD and WIDTH are in cycles.
*/
`timescale 1ns/1ns
module pps_source #(
  parameter int PERIOD = 1000,
  parameter int WIDTH = 50
) (
  // Clock and control
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic slip_i,
  // Reference pulse pin
  output logic pps_o
);
  int cnt_ff;

  // Slip holds the count, delaying every later pulse by one cycle per cycle of slip
  always_ff @(posedge clk_i) begin
    if (!en_i) begin
      cnt_ff <= 0;
    end else if (!slip_i) begin
      cnt_ff <= (cnt_ff == PERIOD - 1) ? 0 : cnt_ff + 1;
    end
  end

  // Pulse lasts 2 us, twice the shortest allowed
  assign pps_o = en_i && (cnt_ff < WIDTH);
endmodule

// File: test/test_pps_discipline_and_output_pin.sv
/*
  Self-checking bench of the pulse disciplining block and its output pin.
  Assumes pps_source as the reference, a 1000-cycle second and a 4 s lock hold.
*/
`timescale 1ns/1ns
`include "pps_defines.svh"
module test_pps_discipline_and_output_pin;
  import pps_pkg::*;
  localparam int SEC = 1000;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic pps_in_i, mpo_o, tune_stb_o, src_en, slip;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, status_i, tune_o, rd;
  disc_stat_s stat_o;
  int n_fail, checks, n, t0, t1;

  pps_discipline #(.SEC_CYC(SEC), .LOCK_SEC(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .status_i(status_i), .pps_in_i(pps_in_i), .mpo_o(mpo_o), .tune_o(tune_o),
    .tune_stb_o(tune_stb_o), .stat_o(stat_o));
  pps_source #(.PERIOD(SEC), .WIDTH(50)) src_u (.clk_i(clk_i), .en_i(src_en),
    .slip_i(slip), .pps_o(pps_in_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk("bus ack", 1, i < 20);
    if (i == 20) end_sim();
  endtask

  // Event 0: regulating state, 1: external lock, 2: tuning strobe
  task automatic wait_ev(input int which, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge clk_i);
      if (which == 0 && stat_o.state === 3'h4) break;
      if (which == 1 && stat_o.ext_lock === 1'b1) break;
      if (which == 2 && tune_stb_o === 1'b1) break;
    end
    chk("event in time", 1, i < lim);
    if (i == lim) end_sim();
  endtask

  task automatic count(input int which, input int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge clk_i);
      if ((which == 0) ? mpo_o === 1'b1 : tune_stb_o === 1'b1) n++;
    end
  endtask

  function automatic logic [31:0] ctrl(input logic [2:0] a, input logic [4:0] s,
      input logic [2:0] m, input logic t);
    ctrl_s c;
    c = '{rsvd: 20'h0, avg: a, sel: s, mode: m, track: t};
    return c;
  endfunction

  // Status word as the pin sees it with tracking off and no lock
  function automatic logic exp_pin(input logic [2:0] m, input logic [31:0] st,
      input logic [4:0] s);
    logic [31:0] w;
    w = st;
    w[25:23] = 3'b010;
    return (m == `MODE_LOCK) ? !w[s] : w[s];
  endfunction

  initial begin
    int k;
    logic [4:0] s;
    logic [2:0] m;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    status_i = 32'h0;
    src_en = 1'b0;
    slip = 1'b0;
    n_fail = 0;
    checks = 0;
    void'($urandom(32'h7CBD3CD2));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, `REG_CTRL, 0);
    chk("ctrl reset", `CTRL_RST, rd);
    wb(0, `REG_GAIN, 0);
    chk("gain reset", `GAIN_RST, rd);
    wb(0, 8'h18, 0);
    chk("unmapped read", 0, rd);
    for (k = 0; k < 7; k++) begin
      wb(1, `REG_CTRL, ctrl(3'(k), 16, `MODE_PULSE, 0));
      wb(0, `REG_CTRL, 0);
      chk("avg state", ctrl(3'(k), 16, `MODE_PULSE, 0), rd);
    end
    wb(1, `REG_CTRL, ctrl(7, 16, `MODE_LOCK, 0));
    wb(0, `REG_CTRL, 0);
    chk("avg 7 refused", ctrl(6, 16, `MODE_LOCK, 0), rd);
    $display("test registers done");
    status_i <= $urandom() & 32'hFFCF_FFFF;
    src_en <= 1'b1;
    for (k = 1; k < 3; k++) begin
      wb(1, `REG_CTRL, ctrl(0, 16, 3'(k), 1));
      count(0, 1200);
      chk("steady pin", (k == 1) ? 1200 : 0, n);
      chk("idle unheated", 0, stat_o.state);
    end
    $display("test unheated done");
    for (k = 0; k < 8; k++) begin
      s = (k == 0) ? 5'd16 : (k > 5) ? 5'(18 + k) : 5'($urandom_range(22, 0));
      m = k[0] ? `MODE_LOCK : `MODE_LOCK_INV;
      status_i <= $urandom();
      wb(1, `REG_CTRL, ctrl(0, s, m, 0));
      repeat (3) @(posedge clk_i);
      chk("lock pin", exp_pin(m, status_i, s), mpo_o);
    end
    $display("test lock pin done");
    status_i <= $urandom() | 32'h0031_0000;
    wb(1, `REG_CTRL, ctrl(0, 16, `MODE_PULSE, 1));
    wait_ev(0, 30 * SEC);
    chk("regulating", 1, stat_o.regulating);
    wb(0, `REG_STATE, 0);
    chk("state reg", 16'h00F4, rd[15:0]);
    count(0, SEC);
    chk("pulse high", 250, n);
    wb(1, `REG_CTRL, ctrl(0, 16, `MODE_PULSE_INV, 1));
    count(0, SEC);
    chk("pulse low", SEC - 250, n);
    wb(1, `REG_CTRL, ctrl(0, 16, `MODE_PULSE, 1));
    wait_ev(1, 8 * SEC);
    wb(0, `REG_STATUS, 0);
    chk("status lock bits", 3'b111, rd[25:23]);
    $display("test acquisition done");
    wait_ev(2, 2 * SEC);
    @(posedge clk_i);
    t0 = $signed(tune_o);
    slip <= 1'b1;
    repeat (2) @(posedge clk_i);
    slip <= 1'b0;
    wait_ev(2, 2 * SEC);
    @(posedge clk_i);
    t1 = $signed(tune_o);
    chk("lock lost", 0, stat_o.ext_lock);
    wb(0, `REG_PHASE, 0);
    chk("phase late", 2, rd);
    k = 200 * 2 * `CLK_PERIOD_PS / `TUNE_PHASE_PS;
    chk("prop step", 1, (t0 - t1 >= k) && (t0 - t1 <= k + 2));
    wait_ev(2, 2 * SEC);
    @(posedge clk_i);
    chk("integ step", t1 - 2, tune_o);
    wb(1, `REG_CTRL, ctrl(1, 16, `MODE_PULSE, 1));
    wait_ev(2, 20 * SEC);
    wait_ev(2, 20 * SEC);
    count(1, 16 * SEC);
    chk("strobes per interval", 1, n);
    wb(1, `REG_CTRL, ctrl(0, 16, `MODE_PULSE, 0));
    repeat (2) @(posedge clk_i);
    chk("track off idle", 0, stat_o);
    $display("test correction done");
    end_sim();
  end
endmodule
